// ==== src/lpo_pkg.sv ====
// constants, register layout and bus carriers for the oscillator control block
// ----------------------------------------------------------------------------
// Function
// - reserved bits of every oscillator control register always read zero
// - slow oscillator lock bit set blocks further writes to its register
// - slow start-up counter ticks on ultra-low-power clock, length from 3-bit select
// - start-up select codes 0..7 give 3,4,6,10,18,34,66,130 cycles
// - slow ready flag sets after start-up count plus two more sync cycles
// - run-on-request set: oscillator runs only while some peripheral requests it
// - run-on-request clear: enabled oscillator runs regardless of requests
// - in standby: off if keep-in-standby zero, else request rule still applies
// - keep-in-standby one and run-on-request zero: runs all through standby
// - slow register bit 3 gates the 1kHz derived output
// - slow register bit 2 gates the 32kHz output
// - slow register bit 1 switches the slow oscillator on or off
// - ultra-low-power register bit 7 locks that register against writes
// - ultra-low-power trim loaded from factory calibration at startup
// - fast register at 0x20 resets to 0x87070382
// - fast divider codes 0..3 divide output by 1,2,4,8
// - fast band field selects four bands, loaded from factory calibration
// - fast trim splits into temperature upper six and process lower six bits
// ----------------------------------------------------------------------------
package lpo_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REQ_W  = 4;

	// ------------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] SLOW_OFS   = 8'h18;
	localparam logic [ADDR_W-1:0] ULP_OFS    = 8'h1C;
	localparam logic [ADDR_W-1:0] FAST_OFS   = 8'h20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// slow internal oscillator fields
	localparam int SLOW_EN_B    = 1;
	localparam int SLOW_32K_B   = 2;
	localparam int SLOW_1K_B    = 3;
	localparam int SLOW_KEEP_B  = 6;
	localparam int SLOW_REQ_B   = 7;
	localparam int SLOW_SU_LO   = 8;
	localparam int SLOW_LOCK_B  = 12;
	localparam int SLOW_TRIM_LO = 16;
	localparam logic [31:0] SLOW_RESET = 32'h003F0080;
	localparam logic [31:0] SLOW_MASK  = 32'h007F17CE;

	// ultra-low-power oscillator fields
	localparam int ULP_LOCK_B = 7;
	localparam logic [31:0] ULP_MASK = 32'h0000009F;

	// fast internal oscillator fields
	localparam int FAST_EN_B    = 1;
	localparam int FAST_KEEP_B  = 6;
	localparam int FAST_REQ_B   = 7;
	localparam int FAST_DIV_LO  = 8;
	localparam int FAST_TRIM_LO = 16;
	localparam int FAST_BAND_LO = 30;
	localparam int TRIM_HALF    = 6;
	localparam logic [31:0] FAST_RESET = 32'h87070382;
	localparam logic [31:0] FAST_MASK  = 32'hCFFF03C2;

	localparam int STATUS_RDY_B = 0;

	// ------------------------------------------------------------------------
	// start-up timing, in ultra-low-power clock cycles
	// ------------------------------------------------------------------------
	localparam logic [7:0] SYNC_CYCLES = 8'h02;
	localparam logic [7:0] STARTUP_CYCLES [8] = '{
		8'h03, 8'h04, 8'h06, 8'h0A, 8'h12, 8'h22, 8'h42, 8'h82
	};

	typedef enum {ST_OFF, ST_COUNT, ST_READY} lpo_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} lpo_axi_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} lpo_axi_rsp_t;

endpackage

// ==== src/lpo_ctrl.sv ====
// oscillator control and status block with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module lpo_ctrl (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire lpo_pkg::lpo_axi_req_t       axi_req,
	output lpo_pkg::lpo_axi_rsp_t            axi_rsp,
	input  wire logic                        ulp_clk_in,
	input  wire logic                        standby_in,
	input  wire logic                        write_protect_in,
	input  wire logic [lpo_pkg::REQ_W-1:0]   slow_req_in,
	input  wire logic [lpo_pkg::REQ_W-1:0]   fast_req_in,
	input  wire logic [4:0]                  ulp_factory_trim,
	input  wire logic [1:0]                  fast_factory_band,
	input  wire logic [11:0]                 fast_factory_trim,
	output logic                             slow_osc_run,
	output logic                             slow_osc_ready_flag,
	output logic                             slow_full_rate_out_en,
	output logic                             slow_tick_out_en,
	output logic [6:0]                       slow_frequency_trim,
	output logic [4:0]                       ulp_frequency_trim,
	output logic                             fast_osc_run,
	output logic [1:0]                       fast_frequency_band,
	output logic [5:0]                       fast_trim_temperature,
	output logic [5:0]                       fast_trim_process,
	output logic [3:0]                       fast_output_divider
);
	import lpo_pkg::*;
	// ------------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------------
	localparam int SYNC_W = 3 + 2 * REQ_W;
	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	assign raw_in = {ulp_clk_in, standby_in, write_protect_in, slow_req_in, fast_req_in};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate
	logic             ulp_s;
	logic             standby_s;
	logic             wprot_s;
	logic [REQ_W-1:0] slow_req_s;
	logic [REQ_W-1:0] fast_req_s;
	assign {ulp_s, standby_s, wprot_s, slow_req_s, fast_req_s} = sync2_q;
	// ------------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------------
	logic       slow_en_q;
	logic       slow_32k_q;
	logic       slow_1k_q;
	logic       slow_keep_q;
	logic       slow_req_q;
	logic [2:0] slow_su_q;
	logic       slow_lock_q;
	logic [6:0] slow_trim_q;
	logic       ulp_lock_q;
	logic [4:0] ulp_trim_q;
	logic       fast_en_q;
	logic       fast_keep_q;
	logic       fast_req_q;
	logic [1:0] fast_div_q;
	logic [11:0] fast_trim_q;
	logic [1:0] fast_band_q;
	logic       cal_loaded_q;
	logic       slow_rdy_q;
	// read views; reserved positions are constant zero
	logic [31:0] slow_view;
	logic [31:0] ulp_view;
	logic [31:0] fast_view;
	logic [31:0] status_view;
	assign slow_view = {9'h000, slow_trim_q, 3'h0, slow_lock_q, 1'h0, slow_su_q,
		slow_req_q, slow_keep_q, 2'h0, slow_1k_q, slow_32k_q, slow_en_q, 1'h0};
	assign ulp_view = {24'h000000, ulp_lock_q, 2'h0, ulp_trim_q};
	assign fast_view = {fast_band_q, 2'h0, fast_trim_q, 6'h00, fast_div_q,
		fast_req_q, fast_keep_q, 4'h0, fast_en_q, 1'h0};
	assign status_view = {31'h00000000, slow_rdy_q};
	// ------------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------------
	logic              aw_full_q;
	logic              w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              wr_go;
	logic [31:0]       strb_mask;
	logic [31:0]       wr_old;
	logic [31:0]       wr_new;
	logic              wr_mapped;
	assign axi_rsp.awready = !aw_full_q && !bvalid_q;
	assign axi_rsp.wready  = !w_full_q && !bvalid_q;
	assign axi_rsp.bvalid  = bvalid_q;
	assign axi_rsp.bresp   = bresp_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (axi_req.awvalid && axi_rsp.awready) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= axi_req.awaddr;
		end else if (wr_go) begin
			aw_full_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (axi_req.wvalid && axi_rsp.wready) begin
			w_full_q <= 1'b1;
			w_data_q <= axi_req.wdata;
			w_strb_q <= axi_req.wstrb;
		end else if (wr_go) begin
			w_full_q <= 1'b0;
		end
	end
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			strb_mask[b*8 +: 8] = {8{w_strb_q[b]}};
		end
		wr_mapped = 1'b1;
		case (aw_addr_q & 8'hFC)
			SLOW_OFS: wr_old = slow_view;
			ULP_OFS:  wr_old = ulp_view;
			FAST_OFS: wr_old = fast_view;
			STATUS_OFS: wr_old = status_view;
			default: begin
				wr_old    = 32'h00000000;
				wr_mapped = 1'b0;
			end
		endcase
		wr_new = (wr_old & ~strb_mask) | (w_data_q & strb_mask);
	end
	logic slow_wr;
	logic ulp_wr;
	logic fast_wr;
	// locked or protected writes still answer OKAY; software sees no change
	assign slow_wr = wr_go && (aw_addr_q & 8'hFC) == SLOW_OFS && !slow_lock_q && !wprot_s;
	assign ulp_wr  = wr_go && (aw_addr_q & 8'hFC) == ULP_OFS && !ulp_lock_q && !wprot_s;
	assign fast_wr = wr_go && (aw_addr_q & 8'hFC) == FAST_OFS && !wprot_s;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_req.bready) begin
			bvalid_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_en_q   <= SLOW_RESET[SLOW_EN_B];
			slow_32k_q  <= SLOW_RESET[SLOW_32K_B];
			slow_1k_q   <= SLOW_RESET[SLOW_1K_B];
			slow_keep_q <= SLOW_RESET[SLOW_KEEP_B];
			slow_req_q  <= SLOW_RESET[SLOW_REQ_B];
			slow_su_q   <= SLOW_RESET[SLOW_SU_LO +: 3];
			slow_lock_q <= SLOW_RESET[SLOW_LOCK_B];
			slow_trim_q <= SLOW_RESET[SLOW_TRIM_LO +: 7];
		end else if (slow_wr) begin
			slow_en_q   <= wr_new[SLOW_EN_B];
			slow_32k_q  <= wr_new[SLOW_32K_B];
			slow_1k_q   <= wr_new[SLOW_1K_B];
			slow_keep_q <= wr_new[SLOW_KEEP_B];
			slow_req_q  <= wr_new[SLOW_REQ_B];
			slow_su_q   <= wr_new[SLOW_SU_LO +: 3];
			slow_lock_q <= wr_new[SLOW_LOCK_B];
			slow_trim_q <= wr_new[SLOW_TRIM_LO +: 7];
		end
	end

	// factory data is caught on the first edge after reset release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_loaded_q <= 1'b0;
		end else begin
			cal_loaded_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ulp_lock_q <= 1'b0;
			ulp_trim_q <= 5'h00;
		end else if (!cal_loaded_q) begin
			ulp_trim_q <= ulp_factory_trim;
		end else if (ulp_wr) begin
			ulp_lock_q <= wr_new[ULP_LOCK_B];
			ulp_trim_q <= wr_new[4:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_en_q   <= FAST_RESET[FAST_EN_B];
			fast_keep_q <= FAST_RESET[FAST_KEEP_B];
			fast_req_q  <= FAST_RESET[FAST_REQ_B];
			fast_div_q  <= FAST_RESET[FAST_DIV_LO +: 2];
			fast_trim_q <= FAST_RESET[FAST_TRIM_LO +: 12];
			fast_band_q <= FAST_RESET[FAST_BAND_LO +: 2];
		end else if (!cal_loaded_q) begin
			fast_trim_q <= fast_factory_trim;
			fast_band_q <= fast_factory_band;
		end else if (fast_wr) begin
			fast_en_q   <= wr_new[FAST_EN_B];
			fast_keep_q <= wr_new[FAST_KEEP_B];
			fast_req_q  <= wr_new[FAST_REQ_B];
			fast_div_q  <= wr_new[FAST_DIV_LO +: 2];
			fast_trim_q <= wr_new[FAST_TRIM_LO +: 12];
			fast_band_q <= wr_new[FAST_BAND_LO +: 2];
		end
	end

	// ------------------------------------------------------------------------
	// run decisions
	// ------------------------------------------------------------------------
	logic slow_run_c;
	logic fast_run_c;
	assign slow_run_c = slow_en_q
		&& (!slow_req_q || |slow_req_s)
		&& (!standby_s || slow_keep_q);
	assign fast_run_c = fast_en_q
		&& (!fast_req_q || |fast_req_s)
		&& (!standby_s || fast_keep_q);

	// ------------------------------------------------------------------------
	// slow start-up counter on ultra-low-power clock edges
	// ------------------------------------------------------------------------
	logic       ulp_prev_q;
	logic       ulp_tick;
	lpo_state_t su_state_q;
	logic [7:0] su_cnt_q;
	assign ulp_tick = ulp_s && !ulp_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ulp_prev_q <= 1'b0;
		end else begin
			ulp_prev_q <= ulp_s;
		end
	end

	// count is start-up plus sync; a stop at any point restarts from the top
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			su_state_q <= ST_OFF;
			su_cnt_q   <= 8'h00;
			slow_rdy_q <= 1'b0;
		end else begin
			case (su_state_q)
				ST_OFF: begin
					slow_rdy_q <= 1'b0;
					if (slow_run_c) begin
						su_state_q <= ST_COUNT;
						su_cnt_q   <= STARTUP_CYCLES[slow_su_q] + SYNC_CYCLES;
					end
				end
				ST_COUNT: begin
					if (!slow_run_c) begin
						su_state_q <= ST_OFF;
					end else if (ulp_tick) begin
						su_cnt_q <= su_cnt_q - 8'h01;
						if (su_cnt_q == 8'h01) begin
							su_state_q <= ST_READY;
							slow_rdy_q <= 1'b1;
						end
					end
				end
				ST_READY: begin
					if (!slow_run_c) begin
						su_state_q <= ST_OFF;
						slow_rdy_q <= 1'b0;
					end
				end
				default: begin
					su_state_q <= ST_OFF;
					slow_rdy_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	assign axi_rsp.arready = !rvalid_q;
	assign axi_rsp.rvalid  = rvalid_q;
	assign axi_rsp.rdata   = rdata_q;
	assign axi_rsp.rresp   = rresp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
		end else if (axi_req.arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			case (axi_req.araddr & 8'hFC)
				SLOW_OFS:   rdata_q <= slow_view & SLOW_MASK;
				ULP_OFS:    rdata_q <= ulp_view & ULP_MASK;
				FAST_OFS:   rdata_q <= fast_view & FAST_MASK;
				STATUS_OFS: rdata_q <= status_view;
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (axi_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	logic slow_run_q;
	logic fast_run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_run_q <= 1'b0;
			fast_run_q <= 1'b0;
		end else begin
			slow_run_q <= slow_run_c;
			fast_run_q <= fast_run_c;
		end
	end

	assign slow_osc_run          = slow_run_q;
	assign slow_osc_ready_flag   = slow_rdy_q;
	assign slow_full_rate_out_en = slow_32k_q && slow_rdy_q;
	assign slow_tick_out_en      = slow_1k_q && slow_rdy_q;
	assign slow_frequency_trim   = slow_trim_q;
	assign ulp_frequency_trim    = ulp_trim_q;
	assign fast_osc_run          = fast_run_q;
	assign fast_frequency_band   = fast_band_q;
	assign fast_trim_temperature = fast_trim_q[TRIM_HALF +: TRIM_HALF];
	assign fast_trim_process     = fast_trim_q[0 +: TRIM_HALF];
	assign fast_output_divider   = 4'h1 << fast_div_q;

endmodule // lpo_ctrl

`default_nettype wire

// ==== verification/lpo_ctrl_sva.sv ====
// port assertions for the oscillator control block
`timescale 1ns/1ps
`default_nettype none

module lpo_ctrl_sva (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire lpo_pkg::lpo_axi_req_t axi_req,
	input wire lpo_pkg::lpo_axi_rsp_t axi_rsp,
	input wire logic                  ulp_clk_in,
	input wire logic                  standby_in,
	input wire logic                  slow_osc_run,
	input wire logic                  slow_osc_ready_flag,
	input wire logic                  slow_full_rate_out_en,
	input wire logic                  slow_tick_out_en,
	input wire logic [6:0]            slow_frequency_trim,
	input wire logic [4:0]            ulp_frequency_trim,
	input wire logic                  fast_osc_run,
	input wire logic [1:0]            fast_frequency_band,
	input wire logic [5:0]            fast_trim_temperature,
	input wire logic [5:0]            fast_trim_process,
	input wire logic [3:0]            fast_output_divider
);
	import lpo_pkg::*;
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	logic [7:0] ar_q;
	logic [2:0] ulp_q;
	logic [7:0] tick_q;
	logic       rd_slow;
	logic       rd_fast;
	logic       rd_ulp;
	assign rd_slow = axi_rsp.rvalid && ar_q[7:2] == SLOW_OFS[7:2];
	assign rd_fast = axi_rsp.rvalid && ar_q[7:2] == FAST_OFS[7:2];
	assign rd_ulp  = axi_rsp.rvalid && ar_q[7:2] == ULP_OFS[7:2];
	always_ff @(posedge aclk) begin
		if (axi_req.arvalid && axi_rsp.arready)
			ar_q <= axi_req.araddr;
	end
	always_ff @(posedge aclk) begin
		ulp_q <= {ulp_q[1:0], ulp_clk_in};
	end
	// own sync keeps pace with the design's; the range below covers every start-up select
	always_ff @(posedge aclk) begin
		if (!slow_osc_run)
			tick_q <= 8'h00;
		else if (ulp_q[1] && !ulp_q[2])
			tick_q <= tick_q + 8'h01;
	end
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_slow_resv_zero: assert property (
		rd_slow |-> (axi_rsp.rdata & ~SLOW_MASK) == 32'h0) else $error("slow reserved set");
	a_fast_resv_zero: assert property (
		rd_fast |-> (axi_rsp.rdata & ~FAST_MASK) == 32'h0) else $error("fast reserved set");
	a_slow_trim_out: assert property (
		rd_slow |-> axi_rsp.rdata[22:16] == slow_frequency_trim) else $error("slow trim");
	a_ulp_trim_out: assert property (
		rd_ulp |-> axi_rsp.rdata[4:0] == ulp_frequency_trim) else $error("ulp trim");
	a_fast_trim_split: assert property (
		rd_fast |-> {fast_trim_temperature, fast_trim_process} == axi_rsp.rdata[27:16])
		else $error("fast trim split");
	a_fast_band_out: assert property (
		rd_fast |-> fast_frequency_band == axi_rsp.rdata[31:30]) else $error("fast band");
	a_fast_div_out: assert property (
		rd_fast |-> fast_output_divider == 4'h1 << axi_rsp.rdata[9:8]) else $error("divider");
	a_tick_needs_ready: assert property (
		rd_slow |-> slow_tick_out_en == (axi_rsp.rdata[SLOW_1K_B] && slow_osc_ready_flag))
		else $error("1k out gate wrong");
	a_full_needs_ready: assert property (
		rd_slow |-> slow_full_rate_out_en == (axi_rsp.rdata[SLOW_32K_B] && slow_osc_ready_flag))
		else $error("32k out gate wrong");
	a_ready_drops: assert property (
		$fell(slow_osc_run) |-> ##[0:2] !slow_osc_ready_flag) else $error("ready stuck");
	a_ready_after_ticks: assert property (
		$rose(slow_osc_ready_flag) |-> tick_q inside {[8'h04:8'h86]}) else $error("early ready");
	a_read_answer: assert property (
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("no read answer");
	c_ready: cover property ($rose(slow_osc_ready_flag));
	c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
	c_stby_run: cover property (standby_in && fast_osc_run);
endmodule // lpo_ctrl_sva
`default_nettype wire

// ==== verification/test_lpo_ctrl.sv ====
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
`default_nettype none

module test_lpo_ctrl;
	import lpo_pkg::*;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic         aclk = 1'b0;
	logic         aresetn;
	lpo_axi_req_t rq;
	lpo_axi_rsp_t rs;
	logic         ulp, stby, prot, s_run, s_rdy, s_full, s_tick, f_run;
	logic [3:0]   sreq, freq, f_div;
	logic [4:0]   ut, u_trim;
	logic [1:0]   fb, f_band;
	logic [11:0]  ft;
	logic [6:0]   s_trim;
	logic [5:0]   f_temp, f_proc;
	logic [31:0]  t;
	logic [33:0]  sb[$];
	int           miscompares, checked, cyc, n;
	int           su[8] = '{3, 4, 6, 10, 18, 34, 66, 130};

	always #20 aclk = ~aclk;

	lpo_ctrl dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
		.ulp_clk_in(ulp), .standby_in(stby), .write_protect_in(prot),
		.slow_req_in(sreq), .fast_req_in(freq), .ulp_factory_trim(ut),
		.fast_factory_band(fb), .fast_factory_trim(ft), .slow_osc_run(s_run),
		.slow_osc_ready_flag(s_rdy), .slow_full_rate_out_en(s_full),
		.slow_tick_out_en(s_tick), .slow_frequency_trim(s_trim),
		.ulp_frequency_trim(u_trim), .fast_osc_run(f_run), .fast_frequency_band(f_band),
		.fast_trim_temperature(f_temp), .fast_trim_process(f_proc),
		.fast_output_divider(f_div));
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
		input logic [3:0] s = 4'hF);
		logic da, dw;
		sb.push_back({r, 32'h0});
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		rq.awaddr  <= a;
		rq.wdata   <= d;
		rq.wstrb   <= s;
		rq.awvalid <= 1'b1;
		rq.wvalid  <= 1'b1;
		rq.bready  <= 1'b1;
		do begin
			@(negedge aclk);
			da = da | (rq.awvalid && rs.awready);
			dw = dw | (rq.wvalid && rs.wready);
			@(posedge aclk);
			if (da)
				rq.awvalid <= 1'b0;
			if (dw)
				rq.wvalid <= 1'b0;
		end while (!(da && dw));
		do @(negedge aclk); while (!rs.bvalid);
		@(posedge aclk);
		rq.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		sb.push_back({r, e});
		@(posedge aclk);
		rq.araddr  <= a;
		rq.arvalid <= 1'b1;
		rq.rready  <= 1'b1;
		do @(negedge aclk); while (!rs.arready);
		@(posedge aclk);
		rq.arvalid <= 1'b0;
		do @(negedge aclk); while (!rs.rvalid);
		@(posedge aclk);
		rq.rready <= 1'b0;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge aclk);
		@(negedge aclk);
	endtask
	// ------------------------------------------------------------------
	// response scoreboard and watchdog
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (rs.rvalid && rq.rready)
			chk({rs.rresp, rs.rdata}, sb.pop_front());
		if (rs.bvalid && rq.bready)
			chk({rs.bresp, 32'h0}, sb.pop_front());
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(14385));
		rq = '0;
		aresetn = 1'b0;
		{ulp, stby, prot, sreq, freq} = '0;
		ut = 5'($urandom);
		fb = 2'($urandom);
		ft = 12'($urandom);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(SLOW_OFS, SLOW_RESET);
		rd(FAST_OFS, {fb, 2'b0, ft, 16'h0382});
		rd(ULP_OFS, {27'h0, ut});
		rd(STATUS_OFS, 32'h0);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h44, 32'h1, RESP_SLVERR);
		chk(f_div, 4'h8);
		wr(SLOW_OFS, 32'hFFDAE831 & SLOW_MASK);
		rd(SLOW_OFS, 32'h005A0000);
		chk(s_trim, 7'h5A);
		for (int d = 0; d < 4; d++) begin
			t = {d[1:0], 2'b11, 12'($urandom), 6'h3F, d[1:0], 8'h3F} & FAST_MASK;
			wr(FAST_OFS, t);
			rd(FAST_OFS, t & FAST_MASK);
			chk(f_div, 4'h1 << d);
			chk(f_band, d[1:0]);
			chk({f_temp, f_proc}, t[27:16]);
		end
		// every mix of enable, on-request, keep, standby and request
		for (int i = 0; i < 32; i++) begin
			stby <= i[3];
			sreq <= i[4] ? 4'($urandom_range(15, 1)) : 4'h0;
			freq <= i[4] ? 4'($urandom_range(15, 1)) : 4'h0;
			t = {24'h0, i[1], i[2], 4'h0, i[0], 1'b0};
			wr(SLOW_OFS, t);
			wr(FAST_OFS, t);
			settle(5);
			rd(FAST_OFS, t);
			n = i[0] && (!i[1] || i[4]) && (!i[3] || i[2]);
			chk(s_run, n);
			chk(f_run, n);
		end
		stby <= 1'b0;
		sreq <= 4'h0;
		// ulp clock held still until run is up, so each tick is counted once
		for (int c = 0; c < 8; c++) begin
			wr(SLOW_OFS, 32'h0);
			settle(3);
			chk(s_rdy, 1'b0);
			wr(SLOW_OFS, 32'h2 | (c << 8));
			settle(6);
			n = 0;
			while (!s_rdy && n < 200) begin
				n++;
				repeat (2) begin
					repeat (6) @(posedge aclk);
					ulp <= ~ulp;
				end
				@(negedge aclk);
			end
			chk(n, su[c] + 2);
		end
		wr(SLOW_OFS, 32'h0706);
		settle(2);
		chk({s_full, s_tick}, 2'b10);
		wr(SLOW_OFS, 32'h070A);
		settle(2);
		chk({s_full, s_tick}, 2'b01);
		rd(STATUS_OFS, 32'h1);
		wr(SLOW_OFS, 32'h170A);
		wr(SLOW_OFS, 32'h0);
		rd(SLOW_OFS, 32'h170A);
		chk(s_run, 1'b1);
		wr(ULP_OFS, 32'h85);
		wr(ULP_OFS, 32'h03);
		rd(ULP_OFS, 32'h85);
		chk(u_trim, 5'h05);
		prot <= 1'b1;
		settle(3);
		wr(FAST_OFS, 32'h0);
		rd(FAST_OFS, 32'hC2);
		prot <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(SLOW_OFS, SLOW_RESET);
		wr(ULP_OFS, 32'h09);
		rd(ULP_OFS, 32'h09);
		// byte lane merge: only the divider byte is replaced
		wr(FAST_OFS, 32'h00000100, RESP_OKAY, 4'h2);
		rd(FAST_OFS, {fb, 2'b0, ft, 16'h0182});
		chk(f_div, 4'h2);
		end_sim();
	end
endmodule // test_lpo_ctrl

bind lpo_ctrl lpo_ctrl_sva u_sva (
	.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.ulp_clk_in(ulp_clk_in), .standby_in(standby_in), .slow_osc_run(slow_osc_run),
	.slow_osc_ready_flag(slow_osc_ready_flag), .slow_full_rate_out_en(slow_full_rate_out_en),
	.slow_tick_out_en(slow_tick_out_en), .slow_frequency_trim(slow_frequency_trim),
	.ulp_frequency_trim(ulp_frequency_trim), .fast_osc_run(fast_osc_run),
	.fast_frequency_band(fast_frequency_band), .fast_trim_temperature(fast_trim_temperature),
	.fast_trim_process(fast_trim_process), .fast_output_divider(fast_output_divider)
);
`default_nettype wire
